// [design/crs_pkg.sv]
package crs_pkg;
	// register file geometry
	localparam int unsigned GPR_COUNT  = 16;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned IDX_W      = 4;
	localparam logic [3:0]  INDEX_REG  = 4'h0;  // index register number
	localparam logic [3:0]  STACK_REG  = 4'hf;  // stack register number
	// status word fields
	localparam int unsigned SW_T_BIT   = 0;     // condition flag
	localparam int unsigned SW_MASK_LO = 4;     // interrupt mask low bit
	localparam logic [3:0]  MASK_RESET = 4'hf;
	localparam logic [31:0] SW_USED    = 32'h0000_03f3; // non-reserved bits
	localparam logic [31:0] VBR_RESET  = 32'h0000_0000;
	// vector table offsets, longword entries
	localparam logic [31:0] VEC_PC_OFS = 32'h0000_0000;
	localparam logic [31:0] VEC_SP_OFS = 32'h0000_0004;
	localparam logic [31:0] INSN_STEP  = 32'h0000_0002; // 16-bit instructions
	// timing
	localparam int unsigned CLK_MHZ    = 125;
	localparam int unsigned CYCLE_NS   = 50;   // one basic cycle at 20 MHz
	localparam int unsigned MUL_CYC    = 2;    // within 1..3
	localparam int unsigned MAC_CYC    = 3;    // within 2..3
	localparam int unsigned MULTIPLY_ACC_HIGH_W     = 10;   // 42-bit accumulator upper part
	// control register select
	typedef enum logic [2:0] {
		crs_cr_sw   = 3'h0,
		crs_cr_gbp  = 3'h1,
		crs_cr_evb  = 3'h2,
		crs_cr_multiply_acc_high = 3'h3,
		crs_cr_multiply_acc_low = 3'h4,
		crs_cr_ret  = 3'h5,
		crs_cr_ip   = 3'h6
	} crs_cr_t;
	// operations
	typedef enum logic [3:0] {
		crs_op_nop    = 4'h0,
		crs_op_imm_mv = 4'h1, // transfer_op with imm
		crs_op_imm_add= 4'h2,
		crs_op_imm_eq = 4'h3, // equality_compare_op
		crs_op_imm_tst= 4'h4, // bit_test_op
		crs_op_imm_and= 4'h5,
		crs_op_imm_or = 4'h6,
		crs_op_imm_xor= 4'h7,
		crs_op_greater_equal_compare_op = 4'h8, // greater_equal_compare_op
		crs_op_load   = 4'h9, // memory load into register
		crs_op_mul    = 4'ha,
		crs_op_mac    = 4'hb,
		crs_op_bt     = 4'hc, // branch_if_true
		crs_op_bf     = 4'hd, // branch_if_false
		crs_op_jump   = 4'he, // delayed_jump_op
		crs_op_wcr    = 4'hf  // write control register from gpr
	} crs_op_t;
	// memory access size
	typedef enum logic [1:0] {
		crs_sz_byte = 2'h0,
		crs_sz_word = 2'h1,
		crs_sz_long = 2'h2
	} crs_sz_t;
	// top state machine, gray along reset path
	typedef enum logic [1:0] {
		crs_st_fetch_pc = 2'b00,
		crs_st_fetch_sp = 2'b01,
		crs_st_run      = 2'b11,
		crs_st_mult     = 2'b10
	} crs_st_t;
endpackage

// [design/crs_gpr_mem.sv]
// sixteen general registers, two read ports, registered read data
module crs_gpr_mem (
	input  wire logic        core_clk,
	input  wire logic [3:0]  rd_a_idx,
	input  wire logic [3:0]  rd_b_idx,
	output logic      [31:0] rd_a_q,
	output logic      [31:0] rd_b_q,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_idx,
	input  wire logic [31:0] wr_data
);
	logic [31:0] mem_q [crs_pkg::GPR_COUNT]; // contents undefined after reset
	// write port and registered reads
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
		rd_a_q <= mem_q[rd_a_idx];
		rd_b_q <= mem_q[rd_b_idx];
	end
endmodule // crs_gpr_mem

// [design/crs_alignment.sv]
// address alignment check for memory operands
module crs_alignment (
	input  wire logic [31:0] addr,
	input  wire logic [1:0]  size,
	output logic             misaligned
);
	// bytes anywhere, words on 2n, longwords on 4n
	always_comb begin
		unique case (size)
			crs_pkg::crs_sz_word: misaligned = addr[0];
			crs_pkg::crs_sz_long: misaligned = |addr[1:0];
			default:              misaligned = 1'b0;
		endcase
	end
endmodule // crs_alignment

// [design/crs_core.sv]
// Function
// - sixteen general, three control, four system registers
// - register zero is index, some ops use it
// - register fifteen is the stack pointer
// - global base feeds peripheral-relative addressing; here no address is formed from it
// - vector base locates exception vectors
// - multiply registers hold product and accumulation
// - return address and instruction pointer registers
// - reset: mask ones, reserved zero, base zero
// - reset loads stack and pointer from table
// - byte and word loads sign-extended
// - misaligned word or longword raises address error
// - stack holds only aligned longwords
// - immediate sign-extended for move, add, equal
// - immediate zero-extended for test and logic
// - wide constants come from pc-relative table
// - every instruction is sixteen bits
// - basic instruction takes one cycle
// - jump executes following slot first
// - multiply 1-3 cycles, accumulate 2-3
// - flag written only by compares and tests; here status word writes (wcr and the register port) also set it
// - ge compare sets flag, branches test it
// - load-store, bit ops on memory; here the bit ops act on the index register only
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
module crs_core (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        op_valid,     // one decoded instruction this cycle
	input  wire logic [3:0]  op_code,      // crs_op_t
	input  wire logic [3:0]  op_dst,       // destination register
	input  wire logic [3:0]  op_src,       // source register
	input  wire logic [7:0]  op_imm,       // 8-bit immediate / displacement
	input  wire logic [1:0]  op_size,      // memory access size
	input  wire logic [2:0]  op_cr,        // control register select, unused; crs_op_wcr takes its select from op_dst
	input  wire logic [31:0] mem_rdata,    // load data or vector table entry
	input  wire logic [31:0] mem_addr,     // address of the load just made
	input  wire logic        mem_is_stack, // load/store via stack register
	input  wire logic [31:0] rd_addr,      // register port address
	input  wire logic [31:0] wr_data_in,   // register port write data
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [31:0] rd_data_q,
	output logic      [31:0] vec_addr_q,   // vector table fetch address
	output logic             busy_q,       // stall for reset fetch or multiply
	output logic             addr_err_q,   // address error pulse
	output logic      [31:0] ip_q,         // instruction_pointer
	output logic             flag_q        // condition flag
);
	crs_pkg::crs_st_t st_q, st_d;          // sequencer state
	logic [31:0] status_word_q, status_word_d;
	logic [31:0] global_base_pointer_q, global_base_pointer_d;
	logic [31:0] exception_vector_base_q, exception_vector_base_d;
	logic [31:0] multiply_acc_high_q, multiply_acc_high_d;
	logic [31:0] multiply_acc_low_q, multiply_acc_low_d;
	logic [31:0] return_address_reg_q, return_address_reg_d;
	logic [31:0] ip_d;                     // instruction pointer next
	logic [31:0] jump_tgt_q, jump_tgt_d;   // pending delayed target
	logic        jump_pend_q, jump_pend_d; // delay slot outstanding
	logic [1:0]  mcnt_q, mcnt_d;           // multiply cycles left
	logic        mac_q, mac_d;             // accumulate vs plain multiply
	logic [31:0] rd_data_d;
	logic        addr_err_d;
	logic        gpr_we;                   // gpr write enable
	logic [3:0]  gpr_widx;
	logic [31:0] gpr_wdata;
	logic [31:0] gpr_a, gpr_b;             // registered operands
	logic        misal;
	logic [3:0]  op_dst_q;                 // operand capture for late write
	logic [3:0]  op_code_q;
	logic [7:0]  op_imm_q;
	logic        op_valid_q;
	logic [1:0]  op_size_q;                // access size held for the late check
	logic [3:0]  rd_a_sel;                 // first read port register number

	// sign-extend byte or word to longword
	function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
		unique case (sz)
			crs_pkg::crs_sz_byte: sext = {{24{v[7]}}, v[7:0]};
			crs_pkg::crs_sz_word: sext = {{16{v[15]}}, v[15:0]};
			default:              sext = v;
		endcase
	endfunction

	// logic ops with an immediate read and write only the index register
	always_comb begin
		rd_a_sel = op_dst;
		if (op_code inside {crs_pkg::crs_op_imm_tst, crs_pkg::crs_op_imm_and,
			crs_pkg::crs_op_imm_or, crs_pkg::crs_op_imm_xor}) begin
			rd_a_sel = crs_pkg::INDEX_REG;
		end
	end

	// general register file
	crs_gpr_mem i_crs_gpr_mem (
		.core_clk (core_clk),
		.rd_a_idx (rd_a_sel),
		.rd_b_idx (op_src),
		.rd_a_q   (gpr_a),
		.rd_b_q   (gpr_b),
		.wr_en    (gpr_we),
		.wr_idx   (gpr_widx),
		.wr_data  (gpr_wdata)
	);

	// alignment of the current load address
	crs_alignment i_crs_alignment (
		.addr       (mem_addr),
		.size       (mem_is_stack ? 2'(crs_pkg::crs_sz_long) : op_size_q),
		.misaligned (misal)
	);

	// operands come out of the memory one cycle later, so capture op fields
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_valid_q <= 1'b0;
			op_code_q  <= 4'h0;
			op_dst_q   <= 4'h0;
			op_imm_q   <= 8'h00;
			op_size_q  <= 2'h0;
		end else begin
			op_valid_q <= op_valid && (st_q == crs_pkg::crs_st_run);
			op_code_q  <= op_code;
			op_dst_q   <= op_dst;
			op_imm_q   <= op_imm;
			op_size_q  <= op_size;
		end
	end

	// next-state and datapath
	always_comb begin
		st_d = st_q;
		status_word_d = status_word_q;
		global_base_pointer_d = global_base_pointer_q;
		exception_vector_base_d = exception_vector_base_q;
		multiply_acc_high_d = multiply_acc_high_q;
		multiply_acc_low_d = multiply_acc_low_q;
		return_address_reg_d = return_address_reg_q;
		ip_d = ip_q;
		jump_tgt_d = jump_tgt_q;
		jump_pend_d = jump_pend_q;
		mcnt_d = mcnt_q;
		mac_d = mac_q;
		addr_err_d = 1'b0;
		gpr_we = 1'b0;
		gpr_widx = op_dst_q;
		gpr_wdata = 32'h0000_0000;
		rd_data_d = 32'h0000_0000;
		unique case (st_q)
			// reset: pointer then stack from vector table
			crs_pkg::crs_st_fetch_pc: begin
				ip_d = mem_rdata;
				st_d = crs_pkg::crs_st_fetch_sp;
			end
			crs_pkg::crs_st_fetch_sp: begin
				gpr_we = 1'b1;
				gpr_widx = crs_pkg::STACK_REG;
				gpr_wdata = mem_rdata;
				st_d = crs_pkg::crs_st_run;
			end
			// multiplier busy for a fixed count
			crs_pkg::crs_st_mult: begin
				mcnt_d = 2'(mcnt_q - 2'h1);
				if (mcnt_q == 2'h1) begin
					st_d = crs_pkg::crs_st_run;
				end
			end
			default: begin
				// one instruction per cycle, pointer steps 16 bits
				if (op_valid_q) begin
					ip_d = ip_q + crs_pkg::INSN_STEP;
					// the slot has just run, so take the pending target
					if (jump_pend_q) begin
						ip_d = jump_tgt_q;
						jump_pend_d = 1'b0;
					end
					unique case (crs_pkg::crs_op_t'(op_code_q))
						// transfer and sum take the sign-extended immediate
						crs_pkg::crs_op_imm_mv: begin
							gpr_we = 1'b1;
							gpr_wdata = {{24{op_imm_q[7]}}, op_imm_q};
						end
						crs_pkg::crs_op_imm_add: begin
							gpr_we = 1'b1; // flag untouched
							gpr_wdata = gpr_a + {{24{op_imm_q[7]}}, op_imm_q};
						end
						// equality compare writes only the condition flag
						crs_pkg::crs_op_imm_eq: begin
							gpr_widx = crs_pkg::INDEX_REG;
							status_word_d[crs_pkg::SW_T_BIT] =
								(gpr_a == {{24{op_imm_q[7]}}, op_imm_q});
						end
						crs_pkg::crs_op_imm_tst: begin
							status_word_d[crs_pkg::SW_T_BIT] =
								((gpr_a & {24'h00_0000, op_imm_q}) == 32'h0);
						end
						// logic ops keep their result in the index register
						crs_pkg::crs_op_imm_and: begin
							gpr_we = 1'b1;
							gpr_widx = crs_pkg::INDEX_REG;
							gpr_wdata = gpr_a & {24'h00_0000, op_imm_q};
						end
						crs_pkg::crs_op_imm_or: begin
							gpr_we = 1'b1;
							gpr_widx = crs_pkg::INDEX_REG;
							gpr_wdata = gpr_a | {24'h00_0000, op_imm_q};
						end
						crs_pkg::crs_op_imm_xor: begin
							gpr_we = 1'b1;
							gpr_widx = crs_pkg::INDEX_REG;
							gpr_wdata = gpr_a ^ {24'h00_0000, op_imm_q};
						end
						// signed compare, destination against source
						crs_pkg::crs_op_greater_equal_compare_op: begin
							status_word_d[crs_pkg::SW_T_BIT] =
								($signed(gpr_a) >= $signed(gpr_b));
						end
						crs_pkg::crs_op_load: begin
							// register only from memory; pc-relative table for wide constants
							if (misal) begin
								addr_err_d = 1'b1;
							end else begin
								gpr_we = 1'b1;
								gpr_wdata = sext(mem_rdata, op_size_q);
							end
						end
						// product lands low; accumulate keeps a 42-bit sum
						crs_pkg::crs_op_mul, crs_pkg::crs_op_mac: begin
							mac_d = (op_code_q == crs_pkg::crs_op_mac);
							if (op_code_q == crs_pkg::crs_op_mac) begin
								{multiply_acc_high_d, multiply_acc_low_d} =
									{{(32 - crs_pkg::MULTIPLY_ACC_HIGH_W){1'b0}},
									multiply_acc_high_q[crs_pkg::MULTIPLY_ACC_HIGH_W-1:0],
									multiply_acc_low_q} +
									64'($signed(gpr_a[15:0]) * $signed(gpr_b[15:0]));
								mcnt_d = 2'(crs_pkg::MAC_CYC - 1);
							end else begin
								multiply_acc_low_d =
									32'($signed(gpr_a[15:0]) * $signed(gpr_b[15:0]));
								mcnt_d = 2'(crs_pkg::MUL_CYC - 1);
							end
							st_d = crs_pkg::crs_st_mult;
						end
						// conditional branches have no delay slot
						crs_pkg::crs_op_bt: begin
							if (status_word_q[crs_pkg::SW_T_BIT]) begin
								ip_d = ip_q + {{23{op_imm_q[7]}}, op_imm_q, 1'b0};
							end
						end
						crs_pkg::crs_op_bf: begin
							if (!status_word_q[crs_pkg::SW_T_BIT]) begin
								ip_d = ip_q + {{23{op_imm_q[7]}}, op_imm_q, 1'b0};
							end
						end
						// remember the target; the next instruction runs first
						crs_pkg::crs_op_jump: begin
							jump_pend_d = 1'b1;
							jump_tgt_d = ip_q + {{23{op_imm_q[7]}}, op_imm_q, 1'b0};
						end
						// copy a general register into a control or system register
						crs_pkg::crs_op_wcr: begin
							unique case (crs_pkg::crs_cr_t'(op_dst_q[2:0]))
								crs_pkg::crs_cr_sw:   status_word_d = gpr_b & crs_pkg::SW_USED;
								crs_pkg::crs_cr_gbp:  global_base_pointer_d = gpr_b;
								crs_pkg::crs_cr_evb:  exception_vector_base_d = gpr_b;
								crs_pkg::crs_cr_multiply_acc_high: multiply_acc_high_d = gpr_b;
								crs_pkg::crs_cr_multiply_acc_low: multiply_acc_low_d = gpr_b;
								crs_pkg::crs_cr_ret:  return_address_reg_d = gpr_b;
								default: ;
							endcase
						end
						default: ;
					endcase
				end
			end
		endcase
		// register port write from software
		if (wr_stb) begin
			unique case (crs_pkg::crs_cr_t'(rd_addr[2:0]))
				crs_pkg::crs_cr_sw:   status_word_d = wr_data_in & crs_pkg::SW_USED;
				crs_pkg::crs_cr_gbp:  global_base_pointer_d = wr_data_in;
				crs_pkg::crs_cr_evb:  exception_vector_base_d = wr_data_in;
				crs_pkg::crs_cr_multiply_acc_high: multiply_acc_high_d = wr_data_in;
				crs_pkg::crs_cr_multiply_acc_low: multiply_acc_low_d = wr_data_in;
				crs_pkg::crs_cr_ret:  return_address_reg_d = wr_data_in;
				default: ;
			endcase
		end
		// register port read, one cycle later
		if (rd_stb) begin
			unique case (crs_pkg::crs_cr_t'(rd_addr[2:0]))
				crs_pkg::crs_cr_sw:   rd_data_d = status_word_q;
				crs_pkg::crs_cr_gbp:  rd_data_d = global_base_pointer_q;
				crs_pkg::crs_cr_evb:  rd_data_d = exception_vector_base_q;
				crs_pkg::crs_cr_multiply_acc_high: rd_data_d = multiply_acc_high_q;
				crs_pkg::crs_cr_multiply_acc_low: rd_data_d = multiply_acc_low_q;
				crs_pkg::crs_cr_ret:  rd_data_d = return_address_reg_q;
				crs_pkg::crs_cr_ip:   rd_data_d = ip_q;
				default:              rd_data_d = 32'h0000_0000;
			endcase
		end
	end

	// register all state; undefined-at-reset fields get zero here
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= crs_pkg::crs_st_fetch_pc;
			status_word_q <= 32'(crs_pkg::MASK_RESET) << crs_pkg::SW_MASK_LO;
			global_base_pointer_q <= 32'h0000_0000;
			exception_vector_base_q <= crs_pkg::VBR_RESET;
			multiply_acc_high_q <= 32'h0000_0000;
			multiply_acc_low_q <= 32'h0000_0000;
			return_address_reg_q <= 32'h0000_0000;
			ip_q <= 32'h0000_0000;
			jump_tgt_q <= 32'h0000_0000;
			jump_pend_q <= 1'b0;
			mcnt_q <= 2'h0;
			mac_q <= 1'b0;
			rd_data_q <= 32'h0000_0000;
			addr_err_q <= 1'b0;
			vec_addr_q <= crs_pkg::VEC_PC_OFS;
			busy_q <= 1'b1;
			flag_q <= 1'b0;
		end else begin
			st_q <= st_d;
			status_word_q <= status_word_d;
			global_base_pointer_q <= global_base_pointer_d;
			exception_vector_base_q <= exception_vector_base_d;
			multiply_acc_high_q <= multiply_acc_high_d;
			multiply_acc_low_q <= multiply_acc_low_d;
			return_address_reg_q <= return_address_reg_d;
			ip_q <= ip_d;
			jump_tgt_q <= jump_tgt_d;
			jump_pend_q <= jump_pend_d;
			mcnt_q <= mcnt_d;
			mac_q <= mac_d;
			rd_data_q <= rd_data_d;
			addr_err_q <= addr_err_d;
			// vector fetch address follows the next state
			vec_addr_q <= exception_vector_base_d +
				((st_d == crs_pkg::crs_st_fetch_pc) ? crs_pkg::VEC_PC_OFS : crs_pkg::VEC_SP_OFS);
			// stall while fetching vectors or multiplying
			busy_q <= (st_d != crs_pkg::crs_st_run);
			// flag output mirrors the status bit it will hold
			flag_q <= status_word_d[crs_pkg::SW_T_BIT];
		end
	end
endmodule // crs_core

// [dv/crs_core_monitor.sv]
// watches the core ports for load alignment, flag and busy behaviour
module crs_core_monitor (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        op_valid,
	input wire logic [3:0]  op_code,
	input wire logic [1:0]  op_size,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_is_stack,
	input wire logic        rd_stb,
	input wire logic [31:0] rd_data_q,
	input wire logic        busy_q,
	input wire logic        addr_err_q,
	input wire logic        flag_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	// a load taken this cycle
	sequence s_load(logic [1:0] z);
		op_valid && !busy_q && op_code == crs_pkg::crs_op_load && op_size == z;
	endsequence
	sequence s_any_load;
		op_valid && !busy_q && op_code == crs_pkg::crs_op_load;
	endsequence

	property p_byte_ok;
		s_load(crs_pkg::crs_sz_byte) ##1 !mem_is_stack |=> !addr_err_q;
	endproperty
	a_byte_ok: assert property (p_byte_ok) else $error("byte load flagged");
	property p_word_odd;
		s_load(crs_pkg::crs_sz_word) ##1 mem_addr[0] |=> addr_err_q;
	endproperty
	a_word_odd: assert property (p_word_odd) else $error("odd word load missed");
	property p_long_mis;
		s_load(crs_pkg::crs_sz_long) ##1 (mem_addr[1:0] != 2'h0) |=> addr_err_q;
	endproperty
	a_long_mis: assert property (p_long_mis) else $error("long load missed");
	property p_stack_mis;
		s_any_load ##1 (mem_is_stack && mem_addr[1:0] != 2'h0) |=> addr_err_q;
	endproperty
	a_stack_mis: assert property (p_stack_mis) else $error("stack load missed");
	// an error needs a misaligned address
	property p_err_cause;
		addr_err_q |-> $past(mem_addr[1:0]) != 2'h0;
	endproperty
	a_err_cause: assert property (p_err_cause) else $error("error on aligned");
	// sum leaves the condition flag alone
	property p_add_flag;
		op_valid && !busy_q && op_code == crs_pkg::crs_op_imm_add |-> ##2 $stable(flag_q);
	endproperty
	a_add_flag: assert property (p_add_flag) else $error("sum changed flag");
	// stall only follows a multiply
	property p_busy_cause;
		$rose(busy_q) |-> ($past(op_valid) && $past(op_code) inside
			{crs_pkg::crs_op_mul, crs_pkg::crs_op_mac}) || ($past(op_valid, 2)
			&& $past(op_code, 2) inside {crs_pkg::crs_op_mul, crs_pkg::crs_op_mac});
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("stray stall");
	// read data zero outside a read answer
	property p_rd_zero;
		!$past(rd_stb) |-> rd_data_q == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data leak");
endmodule // crs_core_monitor

// [dv/crs_core_bench.sv]
module crs_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk;
	logic        arst_n;
	logic        op_valid;
	logic [3:0]  op_code, op_dst, op_src;
	logic [7:0]  op_imm;
	logic [1:0]  op_size;
	logic [31:0] mem_rdata, mem_addr, rd_addr, wr_data_in;
	logic        mem_is_stack, wr_stb, rd_stb;
	logic [31:0] rd_data_q, vec_addr_q, ip_q;
	logic        busy_q, addr_err_q, flag_q;
	int          n_mismatch;
	int          n_checks;
	int          nbusy;       // stall cycles seen
	logic [31:0] ev;          // expected load result
	logic [1:0]  t_sz [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h2};
	logic [31:0] t_md [6] = '{32'h80, 32'h8001, 32'h1, 32'h2, 32'h3, 32'h12345678};
	logic [31:0] t_ma [6] = '{32'h3, 32'h2, 32'h1, 32'h2, 32'h2, 32'h4};
	logic        t_st [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic        t_er [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	crs_core i_crs_core (.core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid),
		.op_code(op_code), .op_dst(op_dst), .op_src(op_src), .op_imm(op_imm),
		.op_size(op_size), .op_cr(3'h0), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
		.mem_is_stack(mem_is_stack), .rd_addr(rd_addr), .wr_data_in(wr_data_in),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
		.vec_addr_q(vec_addr_q), .busy_q(busy_q), .addr_err_q(addr_err_q),
		.ip_q(ip_q), .flag_q(flag_q));
	// core clock, 8 ns
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// stall cycle counter
	always @(posedge core_clk) begin
		if (busy_q === 1'b1) begin
			nbusy++;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic chkf(input logic e);
		chk({31'h0, flag_q}, {31'h0, e});
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one-cycle register write
	task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr_stb     <= 1'b1;
		rd_addr    <= a;
		wr_data_in <= d;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask
	// read, data stands the next cycle only
	task automatic reg_rd(input logic [31:0] a, input logic [31:0] e);
		@(posedge core_clk);
		rd_stb  <= 1'b1;
		rd_addr <= a;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1 chk(rd_data_q, e);
	endtask
	// wait out any stall
	task automatic idle();
		for (int k = 0; k < 50 && busy_q !== 1'b0; k++) begin
			@(posedge core_clk);
		end
	endtask
	// issue one instruction, memory data in its execute cycle
	task automatic op(input crs_pkg::crs_op_t c, input logic [3:0] d, input logic [3:0] s,
		input logic [7:0] i, input logic [1:0] z, input logic [31:0] md,
		input logic [31:0] ma, input logic st, input logic er);
		idle();
		@(posedge core_clk);
		op_valid <= 1'b1;
		op_code  <= c;
		op_dst   <= d;
		op_src   <= s;
		op_imm   <= i;
		op_size  <= z;
		@(posedge core_clk);
		op_valid     <= 1'b0;
		mem_rdata    <= md;
		mem_addr     <= ma;
		mem_is_stack <= st;
		@(posedge core_clk);
		#1 chk({31'h0, addr_err_q}, {31'h0, er});
	endtask
	task automatic opi(input crs_pkg::crs_op_t c, input logic [3:0] d, input logic [7:0] i);
		op(c, d, 4'h0, i, 2'h0, 32'h0, 32'h0, 1'b0, 1'b0);
	endtask
	task automatic opr(input crs_pkg::crs_op_t c, input logic [3:0] d, input logic [3:0] s);
		op(c, d, s, 8'h0, 2'h0, 32'h0, 32'h0, 1'b0, 1'b0);
	endtask
	// copy a general register to global base and read it
	task automatic peek(input logic [3:0] s, input logic [31:0] e);
		opr(crs_pkg::crs_op_wcr, 4'h1, s);
		reg_rd(32'h1, e);
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{arst_n, op_valid, wr_stb, rd_stb, mem_is_stack} = 5'h0;
		{op_code, op_dst, op_src, op_imm, op_size} = 22'h0;
		{mem_addr, rd_addr, wr_data_in} = 96'h0;
		mem_rdata = 32'h0000_0100;
		n_mismatch = 0;
		n_checks = 0;
		nbusy = 0;
		@(posedge core_clk);
		#1 chk(ip_q, 32'h0);
		chk(vec_addr_q, crs_pkg::VBR_RESET);
		@(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		mem_rdata <= 32'h0000_2000;
		#1 chk(vec_addr_q, crs_pkg::VBR_RESET + crs_pkg::VEC_SP_OFS);
		@(posedge core_clk);
		#1 chk(ip_q, 32'h100);
		idle();
		reg_wr(32'h6, 32'h0);
		reg_rd(32'h6, 32'h100);
		reg_rd(32'h0, 32'hf0);
		reg_rd(32'h2, crs_pkg::VBR_RESET);
		reg_rd(32'h7, 32'h0);
		peek(crs_pkg::STACK_REG, 32'h2000);
		reg_rd(32'h6, 32'h100 + crs_pkg::INSN_STEP);
		opi(crs_pkg::crs_op_jump, 4'h0, 8'h10);
		opi(crs_pkg::crs_op_imm_mv, 4'h5, 8'h2a);
		reg_rd(32'h6, 32'h122);
		peek(4'h5, 32'h2a);
		opi(crs_pkg::crs_op_bf, 4'h0, 8'h08);
		reg_rd(32'h6, 32'h134);
		opi(crs_pkg::crs_op_bt, 4'h0, 8'h08);
		reg_rd(32'h6, 32'h136);
		foreach (t_sz[k]) begin
			if (k < 5) begin
				reg_wr(k + 1, 32'ha5a5_5a5a ^ k);
				reg_rd(k + 1, 32'ha5a5_5a5a ^ k);
			end
		end
		chk(vec_addr_q, 32'ha5a5_5a5f);
		reg_wr(32'h0, 32'hffff_ffff);
		reg_rd(32'h0, crs_pkg::SW_USED);
		reg_wr(32'h0, 32'h0);
		opi(crs_pkg::crs_op_imm_mv, 4'h0, 8'h00);
		opi(crs_pkg::crs_op_imm_tst, 4'h0, 8'hff);
		chkf(1'b1);
		opi(crs_pkg::crs_op_imm_mv, 4'h1, 8'h80);
		peek(4'h1, 32'hffff_ff80);
		opi(crs_pkg::crs_op_imm_add, 4'h1, 8'h01);
		chkf(1'b1);
		peek(4'h1, 32'hffff_ff81);
		opi(crs_pkg::crs_op_imm_mv, 4'h2, 8'hfe);
		opi(crs_pkg::crs_op_imm_eq, 4'h2, 8'hfe);
		chkf(1'b1);
		opi(crs_pkg::crs_op_imm_eq, 4'h2, 8'h7e);
		chkf(1'b0);
		opi(crs_pkg::crs_op_imm_mv, 4'h0, 8'hff);
		opi(crs_pkg::crs_op_imm_and, 4'h0, 8'h80);
		peek(crs_pkg::INDEX_REG, 32'h80);
		opi(crs_pkg::crs_op_imm_or, 4'h0, 8'h81);
		opi(crs_pkg::crs_op_imm_xor, 4'h0, 8'h80);
		peek(crs_pkg::INDEX_REG, 32'h01);
		opi(crs_pkg::crs_op_imm_tst, 4'h0, 8'h01);
		chkf(1'b0);
		ev = 32'h0;
		foreach (t_sz[k]) begin
			op(crs_pkg::crs_op_load, 4'h3, 4'h0, 8'h0, t_sz[k], t_md[k], t_ma[k], t_st[k], t_er[k]);
			if (k == 0) ev = 32'hffff_ff80;
			if (k == 1) ev = 32'hffff_8001;
			if (k == 5) ev = 32'h1234_5678;
			peek(4'h3, ev);
		end
		opi(crs_pkg::crs_op_imm_mv, 4'h1, 8'h05);
		opi(crs_pkg::crs_op_imm_mv, 4'h2, 8'h07);
		nbusy = 0;
		opr(crs_pkg::crs_op_greater_equal_compare_op, 4'h1, 4'h2);
		chkf(1'b0);
		opr(crs_pkg::crs_op_greater_equal_compare_op, 4'h2, 4'h1);
		chkf(1'b1);
		opr(crs_pkg::crs_op_greater_equal_compare_op, 4'h1, 4'h1);
		chkf(1'b1);
		chk(nbusy, 0);
		opr(crs_pkg::crs_op_mul, 4'h1, 4'h2);
		idle();
		chk(nbusy, crs_pkg::MUL_CYC - 1);
		reg_rd(32'h4, 32'h23);
		reg_wr(32'h3, 32'h0);
		reg_wr(32'h4, 32'h10);
		nbusy = 0;
		opr(crs_pkg::crs_op_mac, 4'h1, 4'h2);
		idle();
		chk(nbusy, crs_pkg::MAC_CYC - 1);
		reg_rd(32'h4, 32'h33);
		tally_and_finish();
	end
endmodule // crs_core_bench

bind crs_core crs_core_monitor i_crs_core_monitor (.core_clk(core_clk), .arst_n(arst_n),
	.op_valid(op_valid), .op_code(op_code), .op_size(op_size), .mem_addr(mem_addr),
	.mem_is_stack(mem_is_stack), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
	.busy_q(busy_q), .addr_err_q(addr_err_q), .flag_q(flag_q));
